// ### design/adcsc_pkg.sv
// Constants, types and helper functions of the converter sequencer control.
// Function
// - Writing one to start_conversion begins converting the channel chosen by channel_select.
// - Hardware clears start_conversion itself once the conversion has begun.
// - Channel codes 0 to 7 select analog inputs zero to seven; 8 to 15 reserved.
// - analog_input_disable zero enables inputs, one disables them; set when unused.
// - Conversion time field selects 39, 78, 156, 312, 624 or 1248 clock cycles.
// - ladder_always_on zero connects ladder only while converting; one keeps it connected.
// - Control B bits 7 and 6 read as undefined values.
// - Stop, slow or sleep mode resets both control registers and blocks writes.
// - Completion loads the result, sets conversion_done_flag and pulses conversion_done_irq together.
// - Reading the result register clears conversion_done_flag.
// - converter_busy_flag is one while converting; cleared on stop or slow mode.
// - Starting again before reading clears the done flag but keeps the old result.
// - Status bits 7, 6 and 3 to 0 are unstable; only done and busy count.
// - Stop or slow mode aborts conversion, result indeterminate, no automatic restart.
package adcsc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int CH_W   = 4;
  localparam int NUM_CH = 8;
  localparam int TIME_W = 3;
  localparam int CYC_W  = 11;
  localparam int SAR_W  = 8;

  localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 8'h0E;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 8'h0F;
  localparam logic [ADDR_W-1:0] ADDR_RESULT = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h21;

  localparam logic [DATA_W-1:0] CTRL_A_RST = 8'h10;
  localparam logic [DATA_W-1:0] CTRL_B_RST = 8'h00;
  localparam logic [DATA_W-1:0] RESULT_RST = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO  = 8'h00;

  // Control A fields
  localparam int CA_START_BIT = 7;
  localparam int CA_DIS_BIT   = 4;
  localparam int CA_CH_LSB    = 0;
  // Control B fields; bits 7 and 6 are not stored
  localparam int CB_LADDER_BIT = 5;
  localparam int CB_TIME_LSB   = 1;
  localparam int CB_STORE_W    = 6;
  // Status fields
  localparam int ST_DONE_BIT = 5;
  localparam int ST_BUSY_BIT = 4;

  localparam logic [CH_W-1:0] CH_LAST = 4'h7;

  localparam logic [TIME_W-1:0] TIME_39   = 3'h0;
  localparam logic [TIME_W-1:0] TIME_78   = 3'h2;
  localparam logic [TIME_W-1:0] TIME_156  = 3'h3;
  localparam logic [TIME_W-1:0] TIME_312  = 3'h4;
  localparam logic [TIME_W-1:0] TIME_624  = 3'h5;
  localparam logic [TIME_W-1:0] TIME_1248 = 3'h6;

  localparam logic [CYC_W-1:0] CYC_39   = 11'h027;
  localparam logic [CYC_W-1:0] CYC_78   = 11'h04E;
  localparam logic [CYC_W-1:0] CYC_156  = 11'h09C;
  localparam logic [CYC_W-1:0] CYC_312  = 11'h138;
  localparam logic [CYC_W-1:0] CYC_624  = 11'h270;
  localparam logic [CYC_W-1:0] CYC_1248 = 11'h4E0;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } adcsc_state_t;

  // Reserved codes fall back to the longest time: slow is always safe for the analog side
  function automatic logic [CYC_W-1:0] conv_cycles(input logic [TIME_W-1:0] code);
    case (code)
      TIME_39:  conv_cycles = CYC_39;
      TIME_78:  conv_cycles = CYC_78;
      TIME_156: conv_cycles = CYC_156;
      TIME_312: conv_cycles = CYC_312;
      TIME_624: conv_cycles = CYC_624;
      default:  conv_cycles = CYC_1248;
    endcase
  endfunction

  // One-hot enable of a single analog input; reserved codes enable none
  function automatic logic [NUM_CH-1:0] chan_onehot(input logic [CH_W-1:0] code,
                                                     input logic          disable_in);
    logic [NUM_CH-1:0] hot;
    hot = '0;
    if (!disable_in && code <= CH_LAST) begin
      hot[code[2:0]] = 1'b1;
    end
    chan_onehot = hot;
  endfunction

endpackage

// ### design/adcsc_timer.sv
// Conversion timer: spreads eight bit trials over the selected conversion time.
`timescale 1ns/10ps
`default_nettype none
module adcsc_timer #(
  parameter int CYC_W = 11,
  parameter int STEPS = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic             abort_i,
  input  wire logic [CYC_W-1:0] cycles_i,
  output var  logic             step_o,
  output var  logic             end_o
);

  logic             run_ff;
  logic [CYC_W-1:0] total_ff;
  logic [CYC_W-1:0] elapsed_ff;
  logic [CYC_W-1:0] gap_ff;
  logic [CYC_W-1:0] sub_ff;
  logic [4:0]       steps_ff;
  logic [CYC_W-1:0] gap_start;

  // Two cycles short of an even share: each trial needs three cycles for the
  // comparator synchroniser, and the last trial must settle before the end
  assign gap_start = (cycles_i >> $clog2(STEPS)) - 2'h2;
  assign step_o    = run_ff && (sub_ff == gap_ff) && (steps_ff < 5'(STEPS));
  assign end_o     = run_ff && (elapsed_ff == total_ff - 1'b1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_ff     <= 1'b0;
      total_ff   <= '0;
      elapsed_ff <= '0;
      gap_ff     <= '0;
      sub_ff     <= '0;
      steps_ff   <= '0;
    end else if (abort_i || end_o) begin
      run_ff <= 1'b0;
    end else if (start_i) begin
      run_ff     <= 1'b1;
      total_ff   <= cycles_i;
      elapsed_ff <= '0;
      gap_ff     <= gap_start;
      sub_ff     <= '0;
      steps_ff   <= '0;
    end else if (run_ff) begin
      elapsed_ff <= elapsed_ff + 1'b1;
      sub_ff     <= step_o ? '0 : sub_ff + 1'b1;
      steps_ff   <= steps_ff + 5'(step_o);
    end
  end

endmodule
`default_nettype wire

// ### design/adcsc_sar.sv
// Successive approximation register: one trial bit per step, MSB first.
`timescale 1ns/10ps
`default_nettype none
module adcsc_sar #(
  parameter int SAR_W = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             start_i,
  input  wire logic             step_i,
  input  wire logic             cmp_i,
  output var  logic [SAR_W-1:0] code_o
);

  logic [SAR_W-1:0] code_ff;
  logic [SAR_W-1:0] bit_ff;
  logic [SAR_W-1:0] kept;

  // Comparator high means input at or above the trial level: keep the bit
  assign kept   = cmp_i ? code_ff : (code_ff & ~bit_ff);
  assign code_o = code_ff;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_ff <= '0;
      bit_ff  <= '0;
    end else if (start_i) begin
      code_ff <= {1'b1, {(SAR_W-1){1'b0}}};
      bit_ff  <= {1'b1, {(SAR_W-1){1'b0}}};
    end else if (step_i && bit_ff != '0) begin
      code_ff <= kept | (bit_ff >> 1);
      bit_ff  <= bit_ff >> 1;
    end
  end

endmodule
`default_nettype wire

// ### design/adcsc_top.sv
// Converter sequencer control: registers, sequencing, flags and power-mode handling.
`timescale 1ns/10ps
`default_nettype none
module adcsc_top #(
  parameter int ADDR_W = adcsc_pkg::ADDR_W,
  parameter int DATA_W = adcsc_pkg::DATA_W,
  parameter int NUM_CH = adcsc_pkg::NUM_CH,
  parameter int SAR_W  = adcsc_pkg::SAR_W
) (
  input  wire logic              CORE_CLK_I,
  input  wire logic              NRST_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WDATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output var  logic [DATA_W-1:0] RDATA_O,
  input  wire logic              STOP_MODE_I,
  input  wire logic              SLOW_MODE_I,
  input  wire logic              SLEEP_MODE_I,
  input  wire logic              COMPARE_I,
  output var  logic [SAR_W-1:0]  DAC_CODE_O,
  output var  logic              LADDER_ON_O,
  output var  logic [NUM_CH-1:0] CH_ENABLE_O,
  output var  logic              BUSY_O,
  output var  logic              DONE_IRQ_O
);

  // Register state
  logic [DATA_W-1:0]     ctrl_a_ff;
  logic [DATA_W-1:0]     nxt_ctrl_a;
  logic [adcsc_pkg::CB_STORE_W-1:0] ctrl_b_ff;
  logic [adcsc_pkg::CB_STORE_W-1:0] nxt_ctrl_b;
  logic [DATA_W-1:0]     result_ff;
  logic [DATA_W-1:0]     nxt_result;
  logic                  done_ff;
  logic                  nxt_done;
  logic                  busy_ff;
  logic                  irq_ff;
  logic [DATA_W-1:0]     rdata_ff;
  logic [DATA_W-1:0]     nxt_rdata;

  // Derived outputs held in flops
  logic                  ladder_ff;
  logic [NUM_CH-1:0]     ch_en_ff;

  // Comparator synchroniser
  logic                  cmp_meta_ff;
  logic                  cmp_sync_ff;

  // Sequencer
  adcsc_pkg::adcsc_state_t state_ff;
  adcsc_pkg::adcsc_state_t nxt_state;

  // Decode
  logic                  sel_ctrl_a;
  logic                  sel_ctrl_b;
  logic                  sel_result;
  logic                  sel_status;
  logic                  low_power;
  logic                  abort_mode;
  logic                  wr_ctrl_a;
  logic                  wr_ctrl_b;
  logic                  rd_result;
  logic                  start_req;
  logic                  begin_conv;
  logic                  abort_conv;
  logic                  step;
  logic                  conv_end;
  logic [SAR_W-1:0]      sar_code;
  logic [adcsc_pkg::TIME_W-1:0] time_code;
  logic [adcsc_pkg::CH_W-1:0]   chan_code;
  logic                  in_disable;
  logic                  ladder_always;
  logic [DATA_W-1:0]     status_word;
  logic [DATA_W-1:0]     ctrl_b_word;

  // ---------------------------------------------------------------
  // Address decode and power modes
  // ---------------------------------------------------------------
  assign sel_ctrl_a = (ADDR_I == adcsc_pkg::ADDR_CTRL_A);
  assign sel_ctrl_b = (ADDR_I == adcsc_pkg::ADDR_CTRL_B);
  assign sel_result = (ADDR_I == adcsc_pkg::ADDR_RESULT);
  assign sel_status = (ADDR_I == adcsc_pkg::ADDR_STATUS);

  // Power-mode levels come from the clock controller on this same clock
  assign low_power  = STOP_MODE_I | SLOW_MODE_I | SLEEP_MODE_I;
  // Sleep keeps a running conversion alive; only stop and slow cut it off
  assign abort_mode = STOP_MODE_I | SLOW_MODE_I;

  // Writes are ignored for as long as a low-power mode lasts
  assign wr_ctrl_a = WR_I && sel_ctrl_a && !low_power;
  assign wr_ctrl_b = WR_I && sel_ctrl_b && !low_power;
  assign rd_result = RD_I && sel_result;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  assign time_code     = ctrl_b_ff[adcsc_pkg::CB_TIME_LSB +: adcsc_pkg::TIME_W];
  assign ladder_always = ctrl_b_ff[adcsc_pkg::CB_LADDER_BIT];
  assign chan_code     = ctrl_a_ff[adcsc_pkg::CA_CH_LSB +: adcsc_pkg::CH_W];
  assign in_disable    = ctrl_a_ff[adcsc_pkg::CA_DIS_BIT];

  // A pending start is taken only from idle and outside low-power modes.
  // A start written during a conversion is dropped rather than restarting.
  assign start_req  = ctrl_a_ff[adcsc_pkg::CA_START_BIT];
  assign begin_conv = start_req && (state_ff == adcsc_pkg::ST_IDLE) && !low_power;
  assign abort_conv = abort_mode && (state_ff == adcsc_pkg::ST_CONV);

  // ---------------------------------------------------------------
  // Control register A
  // ---------------------------------------------------------------
  always_comb begin
    nxt_ctrl_a = ctrl_a_ff;
    if (low_power) begin
      nxt_ctrl_a = adcsc_pkg::CTRL_A_RST;
    end else if (wr_ctrl_a) begin
      // Fixed bits 5 and 6 are stored as software writes them
      nxt_ctrl_a = WDATA_I;
    end else if (start_req) begin
      nxt_ctrl_a[adcsc_pkg::CA_START_BIT] = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Control register B
  // ---------------------------------------------------------------
  always_comb begin
    nxt_ctrl_b = ctrl_b_ff;
    if (low_power) begin
      nxt_ctrl_b = adcsc_pkg::CTRL_B_RST[adcsc_pkg::CB_STORE_W-1:0];
    end else if (wr_ctrl_b) begin
      nxt_ctrl_b = WDATA_I[adcsc_pkg::CB_STORE_W-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Sequencer state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      adcsc_pkg::ST_IDLE: begin
        if (begin_conv) begin
          nxt_state = adcsc_pkg::ST_CONV;
        end
      end
      adcsc_pkg::ST_CONV: begin
        // No automatic restart afterwards: a new start must be written
        if (abort_conv || conv_end) begin
          nxt_state = adcsc_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = adcsc_pkg::ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Result and done flag
  // ---------------------------------------------------------------
  always_comb begin
    nxt_result = result_ff;
    if (abort_conv) begin
      // Aborted data is not trusted; zero is the defined indeterminate value
      nxt_result = adcsc_pkg::RESULT_RST;
    end else if (conv_end) begin
      nxt_result = sar_code;
    end
  end

  // Completion beats a same-cycle result read, so the event is never lost
  always_comb begin
    nxt_done = done_ff;
    if (conv_end && !abort_conv) begin
      nxt_done = 1'b1;
    end else if (begin_conv) begin
      nxt_done = 1'b0;
    end else if (rd_result) begin
      nxt_done = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  // Unstable status bits and undefined control B bits are given as zero
  assign status_word = {2'b00,
                        done_ff,
                        busy_ff,
                        4'h0};
  assign ctrl_b_word = {2'b00, ctrl_b_ff};

  always_comb begin
    nxt_rdata = adcsc_pkg::READ_ZERO;
    if (RD_I) begin
      if (sel_ctrl_a) begin
        nxt_rdata = ctrl_a_ff;
      end else if (sel_ctrl_b) begin
        nxt_rdata = ctrl_b_word;
      end else if (sel_result) begin
        nxt_rdata = result_ff;
      end else if (sel_status) begin
        nxt_rdata = status_word;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------
  adcsc_timer #(
    .CYC_W (adcsc_pkg::CYC_W),
    .STEPS (SAR_W)
  ) u_timer (
    .clk_i    (CORE_CLK_I),
    .rst_n_i  (NRST_I),
    .start_i  (begin_conv),
    .abort_i  (abort_conv),
    .cycles_i (adcsc_pkg::conv_cycles(time_code)),
    .step_o   (step),
    .end_o    (conv_end)
  );

  adcsc_sar #(
    .SAR_W (SAR_W)
  ) u_sar (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (NRST_I),
    .start_i (begin_conv),
    .step_i  (step),
    .cmp_i   (cmp_sync_ff),
    .code_o  (sar_code)
  );

  // ---------------------------------------------------------------
  // Flops
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cmp_meta_ff <= 1'b0;
      cmp_sync_ff <= 1'b0;
    end else begin
      cmp_meta_ff <= COMPARE_I;
      cmp_sync_ff <= cmp_meta_ff;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_a_ff <= adcsc_pkg::CTRL_A_RST;
      ctrl_b_ff <= adcsc_pkg::CTRL_B_RST[adcsc_pkg::CB_STORE_W-1:0];
      state_ff  <= adcsc_pkg::ST_IDLE;
    end else begin
      ctrl_a_ff <= nxt_ctrl_a;
      ctrl_b_ff <= nxt_ctrl_b;
      state_ff  <= nxt_state;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      result_ff <= adcsc_pkg::RESULT_RST;
      done_ff   <= 1'b0;
      irq_ff    <= 1'b0;
      rdata_ff  <= adcsc_pkg::READ_ZERO;
    end else begin
      result_ff <= nxt_result;
      done_ff   <= nxt_done;
      irq_ff    <= conv_end && !abort_conv;
      rdata_ff  <= nxt_rdata;
    end
  end

  // Busy follows the sequencer; ladder and channel enables are registered
  // so the analog side sees glitch-free levels.
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      busy_ff   <= 1'b0;
      ladder_ff <= 1'b0;
      ch_en_ff  <= '0;
    end else begin
      busy_ff   <= (nxt_state == adcsc_pkg::ST_CONV);
      ladder_ff <= ladder_always || (nxt_state == adcsc_pkg::ST_CONV);
      ch_en_ff  <= adcsc_pkg::chan_onehot(chan_code, in_disable);
    end
  end

  assign RDATA_O     = rdata_ff;
  assign DAC_CODE_O  = sar_code;
  assign LADDER_ON_O = ladder_ff;
  assign CH_ENABLE_O = ch_en_ff;
  assign BUSY_O      = busy_ff;
  assign DONE_IRQ_O  = irq_ff;

endmodule
`default_nettype wire

// ### tb/adcsc_top_chk.sv
// Port checker of the converter sequencer control and its bind.
`timescale 1ns/10ps
`default_nettype none
module adcsc_chk #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8,
  parameter int NUM_CH = 8,
  parameter int SAR_W  = 8
) (
  input wire logic              CORE_CLK_I,
  input wire logic              NRST_I,
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [DATA_W-1:0] WDATA_I,
  input wire logic              WR_I,
  input wire logic              RD_I,
  input wire logic [DATA_W-1:0] RDATA_O,
  input wire logic              STOP_MODE_I,
  input wire logic              SLOW_MODE_I,
  input wire logic              SLEEP_MODE_I,
  input wire logic              COMPARE_I,
  input wire logic [SAR_W-1:0]  DAC_CODE_O,
  input wire logic              LADDER_ON_O,
  input wire logic [NUM_CH-1:0] CH_ENABLE_O,
  input wire logic              BUSY_O,
  input wire logic              DONE_IRQ_O
);
  logic [10:0] busy_cnt_ff;
  logic [10:0] nxt_busy_cnt;
  wire logic   low_pwr;
  assign low_pwr = STOP_MODE_I || SLOW_MODE_I;
  assign nxt_busy_cnt = BUSY_O ? busy_cnt_ff + 11'h001 : 11'h000;
  always_ff @(posedge CORE_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      busy_cnt_ff <= 11'h000;
    end else begin
      busy_cnt_ff <= nxt_busy_cnt;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!NRST_I);
  a_start_busy: assert property ((WR_I && ADDR_I == 8'h0E && WDATA_I[7]
    && !BUSY_O && !low_pwr && !SLEEP_MODE_I) ##1 !(low_pwr || SLEEP_MODE_I) |=> BUSY_O)
    else $error("start ignored");
  a_dac_msb: assert property ($rose(BUSY_O) |-> DAC_CODE_O == 8'h80)
    else $error("first trial code wrong");
  a_one_chan: assert property ($onehot0(CH_ENABLE_O)) else $error("several inputs on");
  a_ladder_busy: assert property (BUSY_O |-> LADDER_ON_O) else $error("ladder off");
  a_irq_pulse: assert property (DONE_IRQ_O |=> !DONE_IRQ_O) else $error("irq too long");
  a_irq_ends_busy: assert property (DONE_IRQ_O |-> !BUSY_O && $past(BUSY_O))
    else $error("irq apart from busy end");
  a_abort_quiet: assert property (low_pwr |=> !BUSY_O && !DONE_IRQ_O)
    else $error("abort failed");
  a_conv_length: assert property (DONE_IRQ_O |-> busy_cnt_ff inside {[37:39], [76:78],
    [154:156], [310:312], [622:624], [1246:1248]}) else $error("conversion length wrong");
  a_status_zero: assert property ($past(RD_I && ADDR_I == 8'h21)
    |-> RDATA_O[7:6] == 2'b00 && RDATA_O[3:0] == 4'h0) else $error("status spare bits set");
  a_ctrlb_top: assert property ($past(RD_I && ADDR_I == 8'h0F)
    |-> RDATA_O[7:6] == 2'b00) else $error("control b top bits set");
  a_rdata_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00) else $error("stray data");
endmodule
bind adcsc_top adcsc_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .NUM_CH(NUM_CH), .SAR_W(SAR_W))
  adcsc_chk_inst (.CORE_CLK_I, .NRST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
  .STOP_MODE_I, .SLOW_MODE_I, .SLEEP_MODE_I, .COMPARE_I, .DAC_CODE_O, .LADDER_ON_O,
  .CH_ENABLE_O, .BUSY_O, .DONE_IRQ_O);
`default_nettype wire

// ### tb/adcsc_ain_model.sv
// Model of the eight analog inputs and the comparator behind them.
`timescale 1ns/10ps
`default_nettype none
module adcsc_ain_model (
  input  wire logic        clk_i,
  input  wire logic [63:0] levels_i,
  input  wire logic [7:0]  dac_code_i,
  input  wire logic [7:0]  ch_enable_i,
  output var  logic        cmp_o
);
  logic       toggle_ff = 1'b0;
  logic [7:0] sel_level;
  always @(posedge clk_i) begin
    toggle_ff <= !toggle_ff;
  end
  always_comb begin
    sel_level = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (ch_enable_i[i]) begin
        sel_level = levels_i[i*8 +: 8];
      end
    end
  end
  // No input connected: the comparator output is junk, so it must not settle
  assign cmp_o = ($countones(ch_enable_i) == 1) ? (sel_level >= dac_code_i) : toggle_ff;
endmodule
`default_nettype wire

// ### tb/tb_adcsc_top.sv
// Self-checking testbench of the converter sequencer control.
`timescale 1ns/10ps
`default_nettype none
module tb_adcsc_top;
  logic clk, rst_n, wr, rd, stop_m, slow_m, sleep_m, rd_pend;
  logic [7:0]  addr, wdata;
  logic [63:0] levels;
  wire logic [7:0] rdata, dac, ch_en;
  wire logic cmp, ladder, busy, irq;
  int err_count = 0, checks_done = 0, cyc = 0;
  logic [7:0] exp_q[$];
  int tt[8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};

  adcsc_top adcsc_top_inst (.CORE_CLK_I(clk), .NRST_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .STOP_MODE_I(stop_m), .SLOW_MODE_I(slow_m),
    .SLEEP_MODE_I(sleep_m), .COMPARE_I(cmp), .DAC_CODE_O(dac), .LADDER_ON_O(ladder),
    .CH_ENABLE_O(ch_en), .BUSY_O(busy), .DONE_IRQ_O(irq));
  adcsc_ain_model adcsc_ain_model_inst (.clk_i(clk), .levels_i(levels), .dac_code_i(dac),
    .ch_enable_i(ch_en), .cmp_o(cmp));

  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t read got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t value got %0d expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic start_conv(input logic [3:0] ch, input logic [2:0] tc, input logic lad);
    wr_reg(adcsc_pkg::ADDR_CTRL_B, {2'b00, lad, 1'b1, tc, 1'b0});
    wr_reg(adcsc_pkg::ADDR_CTRL_A, {4'h2, ch});
    wr_reg(adcsc_pkg::ADDR_CTRL_A, {4'hA, ch});
  endtask
  // mid[8] set: result read during the run must still show the old value
  task automatic run_conv(input logic [3:0] ch, input logic [2:0] tc, input logic lad,
                          input int t, input logic [7:0] val, input logic [8:0] mid);
    int t0;
    levels[{ch[2:0], 3'b000} +: 8] <= val;
    start_conv(ch, tc, lad);
    @(negedge clk);
    t0 = cyc;
    rd_reg(adcsc_pkg::ADDR_CTRL_A, {4'h2, ch});
    if (mid[8]) begin
      rd_reg(adcsc_pkg::ADDR_STATUS, 8'h10);
      rd_reg(adcsc_pkg::ADDR_RESULT, mid[7:0]);
    end
    do begin
      @(negedge clk);
    end while (irq !== 1'b1 && cyc - t0 < 1400);
    cmp_val(16'(cyc - t0), 16'(t + 1));
    if (!mid[8]) begin
      rd_reg(adcsc_pkg::ADDR_STATUS, 8'h20);
      rd_reg(adcsc_pkg::ADDR_RESULT, val);
      rd_reg(adcsc_pkg::ADDR_STATUS, 8'h00);
      @(negedge clk);
      cmp_val(16'(ladder), 16'(lad));
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (rd_pend) begin
      cmp_rd(rdata, exp_q.pop_front());
    end
    rd_pend = rd && rst_n;
    if (cyc == 20000) begin
      err_count++;
      $display("BAD %0t run did not finish", $time);
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    {wr, rd, stop_m, slow_m, sleep_m} = '0;
    addr = 8'h00;
    wdata = 8'h00;
    levels = '0;
    void'($urandom(18859));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(adcsc_pkg::ADDR_CTRL_A, 8'h10);
    rd_reg(adcsc_pkg::ADDR_CTRL_B, 8'h00);
    rd_reg(adcsc_pkg::ADDR_RESULT, 8'h00);
    rd_reg(adcsc_pkg::ADDR_STATUS, 8'h00);
    wr_reg(8'h30, 8'hFF);
    rd_reg(8'h30, 8'h00);
    for (int c = 0; c < 17; c++) begin
      wr_reg(adcsc_pkg::ADDR_CTRL_A, (c == 16) ? 8'h32 : {4'h2, c[3:0]});
      repeat (2) @(negedge clk);
      cmp_val(16'(ch_en), (c < 8) ? 16'(1 << c) : 16'h0000);
    end
    for (int i = 0; i < 8; i++) begin
      run_conv(4'($urandom_range(7)), i[2:0], i[0], tt[i], 8'($urandom), 9'h000);
    end
    run_conv(4'h7, 3'h0, 1'b0, 39, 8'hFF, 9'h000);
    run_conv(4'h3, 3'h0, 1'b0, 39, 8'h5A, 9'h000);
    run_conv(4'h3, 3'h0, 1'b0, 39, 8'h00, 9'h000);
    run_conv(4'h5, 3'h0, 1'b0, 39, 8'hC3, 9'h000);
    run_conv(4'h4, 3'h2, 1'b0, 78, 8'h3C, 9'h1C3);
    run_conv(4'h4, 3'h0, 1'b1, 39, 8'h96, 9'h13C);
    rd_reg(adcsc_pkg::ADDR_RESULT, 8'h96);
    sleep_m <= 1'b1;
    wr_reg(adcsc_pkg::ADDR_CTRL_A, 8'h2F);
    wr_reg(adcsc_pkg::ADDR_CTRL_B, 8'h3E);
    rd_reg(adcsc_pkg::ADDR_CTRL_A, 8'h10);
    rd_reg(adcsc_pkg::ADDR_CTRL_B, 8'h00);
    sleep_m <= 1'b0;
    for (int m = 0; m < 2; m++) begin
      start_conv(4'h2, 3'h6, 1'b0);
      repeat (20) @(posedge clk);
      stop_m <= (m == 0);
      slow_m <= (m == 1);
      rd_reg(adcsc_pkg::ADDR_STATUS, 8'h00);
      rd_reg(adcsc_pkg::ADDR_RESULT, 8'h00);
      rd_reg(adcsc_pkg::ADDR_CTRL_A, 8'h10);
      stop_m <= 1'b0;
      slow_m <= 1'b0;
      repeat (50) @(posedge clk);
      rd_reg(adcsc_pkg::ADDR_STATUS, 8'h00);
    end
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule
`default_nettype wire
